// ===== rtl/upc_pkg.sv
// Constants for the user protection and configuration register slice
package upc_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Serial frame layout: command byte then data byte
    localparam logic [4:0] FRAME_HDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_ALL_BITS = 5'h10;
    localparam int CMD_WRITE_BIT = 7;

    // Register offsets
    localparam logic [6:0] ADDR_OV_STATUS = 7'h2A;
    localparam logic [6:0] ADDR_VARIANT_ID = 7'h2B;
    localparam logic [6:0] ADDR_OFF_DELAY = 7'h2C;
    localparam logic [6:0] ADDR_PASSWORD = 7'h2E;
    localparam logic [6:0] ADDR_PROTECT = 7'h2F;
    localparam logic [6:0] ADDR_OPEN_LO = 7'h02;
    localparam logic [6:0] ADDR_OPEN_HI = 7'h09;

    // Field positions
    localparam int OV_AUX1_BIT = 1;
    localparam int OV_AUX2_BIT = 0;
    localparam int PROT_NVM_BIT = 2;
    localparam int PROT_DIRECT_BIT = 1;
    localparam int PROT_WP_BIT = 0;
    localparam int OFF_DELAY_W = 4;
    localparam int PROT_W = 3;
    localparam int DELAY_CNT_W = 17;

    // Reset values
    localparam logic [3:0] OFF_DELAY_RST = 4'h0;
    localparam logic [7:0] PASSWORD_RST = 8'h00;
    localparam logic [2:0] PROT_RST = 3'h0;

    // Unlock sequence bytes
    localparam logic [7:0] UNLOCK_FIRST = 8'hBA;
    localparam logic [7:0] UNLOCK_SECOND = 8'hBE;

    // Lower bound of each off-delay setting in ns
    localparam int OFF_DELAY_NS [16] = '{
        4000, 8010, 16020, 32000, 63990, 128000, 256000, 512100,
        6230, 12460, 24890, 49770, 99500, 199100, 398300, 1024200
    };

    // Least delay rounds up to whole cycles
    function automatic logic [DELAY_CNT_W-1:0] off_delay_cycles(input logic [3:0] sel);
        int ns;
        ns = OFF_DELAY_NS[sel];
        return DELAY_CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : off_delay_cycles

    // Delay count shown in reset, worked out once so reset loads a plain constant
    localparam logic [DELAY_CNT_W-1:0] OFF_DELAY_CYCLES_RST = off_delay_cycles(OFF_DELAY_RST);

endpackage : upc_pkg

// ===== rtl/upc_regs.sv
// Serial-access register slice: overvoltage status, variant id, off delay, password, protection
`timescale 1ns/1ps
`default_nettype none
module upc_regs #(
    // Arbitrary neutral value
    parameter logic [7:0] VARIANT_ID = 8'h5A
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Serial register port, mode 0, MSB first
    input wire logic I_SPI_SCLK,
    input wire logic I_SPI_CS_N,
    input wire logic I_SPI_MOSI,
    output logic O_SPI_MISO,
    // Regulator fault inputs from the analog side
    input wire logic I_AUX_REG1_OV,
    input wire logic I_AUX_REG2_OV,
    // Configuration outputs
    output logic [upc_pkg::OFF_DELAY_W-1:0] O_ILLUMINATION_OFF_DELAY_SEL,
    output logic [upc_pkg::DELAY_CNT_W-1:0] O_OFF_DELAY_CYCLES,
    output logic O_NVM_PROGRAM,
    output logic O_DIRECT_MODE,
    output logic O_UNLOCKED,
    // Accepted writes to registers held elsewhere in the map
    output logic O_EXT_WR,
    output logic [6:0] O_EXT_ADDR,
    output logic [7:0] O_EXT_DATA
);
    import upc_pkg::*;

    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic [1:0] ov1_sync;
    logic [1:0] ov2_sync;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt;
    logic [6:0] shift_in;
    logic [6:0] cmd_addr;
    logic cmd_write;
    logic [7:0] tx_shift;
    logic wr_pulse;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [3:0] off_delay;
    logic [7:0] password;
    logic [2:0] protect;
    logic seen_first;
    logic unlocked;
    logic wp_active;
    logic wr_allowed;

    // Two-stage synchronisers; all pins are asynchronous to I_CLK
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            mosi_sync <= 2'h0;
            ov1_sync <= 2'h0;
            ov2_sync <= 2'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], I_SPI_SCLK};
            cs_sync <= {cs_sync[0], I_SPI_CS_N};
            mosi_sync <= {mosi_sync[0], I_SPI_MOSI};
            ov1_sync <= {ov1_sync[0], I_AUX_REG1_OV};
            ov2_sync <= {ov2_sync[0], I_AUX_REG2_OV};
            sclk_d <= sclk_sync[1];
        end
    end

    // Edges seen only on the second stage
    assign sclk_rise = sclk_sync[1] && !sclk_d && !cs_sync[1];
    assign sclk_fall = !sclk_sync[1] && sclk_d && !cs_sync[1];

    // Frame shifter; bits past the data byte are ignored until select rises
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bit_cnt <= 5'h00;
            shift_in <= 7'h00;
            cmd_addr <= 7'h00;
            cmd_write <= 1'b0;
        end else if (cs_sync[1]) begin
            bit_cnt <= 5'h00;
        end else if (sclk_rise && bit_cnt != FRAME_ALL_BITS) begin
            bit_cnt <= bit_cnt + 5'h01;
            shift_in <= {shift_in[5:0], mosi_sync[1]};
            if (bit_cnt == FRAME_HDR_BITS - 5'h01) begin
                cmd_write <= shift_in[CMD_WRITE_BIT-1];
                cmd_addr <= {shift_in[5:0], mosi_sync[1]};
            end
        end
    end

    // Write strobe on the last data bit of a write frame
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wr_pulse <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
        end else begin
            wr_pulse <= sclk_rise && cmd_write && bit_cnt == FRAME_ALL_BITS - 5'h01;
            wr_addr <= cmd_addr;
            wr_data <= {shift_in, mosi_sync[1]};
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (cmd_addr == ADDR_OV_STATUS) begin
            rd_data[OV_AUX1_BIT] = ov1_sync[1];
            rd_data[OV_AUX2_BIT] = ov2_sync[1];
        end else if (cmd_addr == ADDR_VARIANT_ID) begin
            rd_data = VARIANT_ID;
        end else if (cmd_addr == ADDR_OFF_DELAY) begin
            rd_data = {4'h0, off_delay};
        end else if (cmd_addr == ADDR_PASSWORD) begin
            rd_data = password;
        end else if (cmd_addr == ADDR_PROTECT) begin
            rd_data = {5'h00, protect};
        end
    end

    // First data bit leaves straight from the mux on the fall after bit 8, so the host has it before its ninth rise
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tx_shift <= 8'h00;
            O_SPI_MISO <= 1'b0;
        end else if (cs_sync[1]) begin
            O_SPI_MISO <= 1'b0;
        end else if (sclk_fall && bit_cnt == FRAME_HDR_BITS) begin
            O_SPI_MISO <= !cmd_write && rd_data[7];
            tx_shift <= cmd_write ? 8'h00 : {rd_data[6:0], 1'b0};
        end else if (sclk_fall && bit_cnt > FRAME_HDR_BITS && bit_cnt != FRAME_ALL_BITS) begin
            O_SPI_MISO <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end

    // Write protection is lifted while the password has unlocked the part
    assign wp_active = protect[PROT_WP_BIT] && !unlocked;
    assign wr_allowed = !wp_active || (wr_addr >= ADDR_OPEN_LO && wr_addr <= ADDR_OPEN_HI);

    // Delay selector register
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            off_delay <= OFF_DELAY_RST;
        end else if (wr_pulse && wr_allowed && wr_addr == ADDR_OFF_DELAY) begin
            off_delay <= wr_data[3:0];
        end
    end

    // Password always writable so a protected part can still be opened
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            password <= PASSWORD_RST;
            seen_first <= 1'b0;
            unlocked <= 1'b0;
        end else if (wr_pulse && wr_addr == ADDR_PASSWORD) begin
            password <= wr_data;
            seen_first <= wr_data == UNLOCK_FIRST;
            unlocked <= seen_first && wr_data == UNLOCK_SECOND;
        end else if (wr_pulse) begin
            seen_first <= 1'b0;
        end
    end

    // Protection register; writable while write protection is clear or the part is unlocked
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            protect <= PROT_RST;
        end else if (wr_pulse && wr_allowed && wr_addr == ADDR_PROTECT) begin
            protect <= wr_data[PROT_W-1:0];
        end
    end

    // Forward accepted writes aimed at registers outside this slice
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_EXT_WR <= 1'b0;
            O_EXT_ADDR <= 7'h00;
            O_EXT_DATA <= 8'h00;
        end else begin
            O_EXT_WR <= wr_pulse && wr_allowed && wr_addr != ADDR_OV_STATUS && wr_addr != ADDR_VARIANT_ID
                && wr_addr != ADDR_OFF_DELAY && wr_addr != ADDR_PASSWORD && wr_addr != ADDR_PROTECT;
            O_EXT_ADDR <= wr_addr;
            O_EXT_DATA <= wr_data;
        end
    end

    // Registered configuration outputs
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ILLUMINATION_OFF_DELAY_SEL <= OFF_DELAY_RST;
            O_OFF_DELAY_CYCLES <= OFF_DELAY_CYCLES_RST;
            O_NVM_PROGRAM <= 1'b0;
            O_DIRECT_MODE <= 1'b0;
            O_UNLOCKED <= 1'b0;
        end else begin
            O_ILLUMINATION_OFF_DELAY_SEL <= off_delay;
            O_OFF_DELAY_CYCLES <= off_delay_cycles(off_delay);
            O_NVM_PROGRAM <= protect[PROT_NVM_BIT];
            O_DIRECT_MODE <= protect[PROT_DIRECT_BIT];
            O_UNLOCKED <= unlocked;
        end
    end

endmodule : upc_regs
`default_nettype wire

// ===== dv/upc_regs_monitor.sv
// Port checker for the register slice
`timescale 1ns/1ps
`default_nettype none
module upc_regs_monitor (
    input wire logic I_CLK, I_RSTN, I_SPI_CS_N, O_SPI_MISO,
    input wire logic O_NVM_PROGRAM, O_DIRECT_MODE, O_UNLOCKED, O_EXT_WR,
    input wire logic [3:0] O_ILLUMINATION_OFF_DELAY_SEL,
    input wire logic [16:0] O_OFF_DELAY_CYCLES,
    input wire logic [6:0] O_EXT_ADDR
);
    logic [3:0] quiet;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // Cycles since select was low; outputs may only move during a frame or just after it
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) quiet <= 4'h0;
        else if (!I_SPI_CS_N) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    sequence s_idle; I_SPI_CS_N [*5]; endsequence
    sequence s_sel_held; $stable(O_ILLUMINATION_OFF_DELAY_SEL) [*3]; endsequence
    property p_ext_pulse; O_EXT_WR |=> !O_EXT_WR; endproperty
    property p_ext_local; O_EXT_WR |-> !(O_EXT_ADDR inside {7'h2A, 7'h2B, 7'h2C, 7'h2E, 7'h2F}); endproperty
    property p_miso_idle; s_idle |-> !O_SPI_MISO; endproperty
    property p_cyc; s_sel_held |-> (O_ILLUMINATION_OFF_DELAY_SEL != 4'h0 || O_OFF_DELAY_CYCLES == 17'd400)
        && (O_ILLUMINATION_OFF_DELAY_SEL != 4'h7 || O_OFF_DELAY_CYCLES == 17'd51210)
        && (O_ILLUMINATION_OFF_DELAY_SEL != 4'h8 || O_OFF_DELAY_CYCLES == 17'd623)
        && (O_ILLUMINATION_OFF_DELAY_SEL != 4'hF || O_OFF_DELAY_CYCLES == 17'd102420); endproperty
    property p_sel_quiet; $changed(O_ILLUMINATION_OFF_DELAY_SEL) |-> quiet < 4'hC; endproperty
    property p_mode_quiet; $changed({O_NVM_PROGRAM, O_DIRECT_MODE}) |-> quiet < 4'hC; endproperty
    property p_unlock_quiet; $rose(O_UNLOCKED) |-> quiet < 4'hC; endproperty
    property p_ext_quiet; O_EXT_WR |-> quiet < 4'hC; endproperty
    a_ext_pulse: assert property (p_ext_pulse) else $error("ext write longer than one cycle");
    a_ext_local: assert property (p_ext_local) else $error("local address leaked out");
    a_miso_idle: assert property (p_miso_idle) else $error("miso driven while deselected");
    a_cyc: assert property (p_cyc) else $error("delay cycles wrong for code");
    a_sel_quiet: assert property (p_sel_quiet) else $error("delay select moved unprompted");
    a_mode_quiet: assert property (p_mode_quiet) else $error("mode moved unprompted");
    a_unlock_quiet: assert property (p_unlock_quiet) else $error("unlock without a write");
    a_ext_quiet: assert property (p_ext_quiet) else $error("ext write without a frame");
endmodule : upc_regs_monitor
bind upc_regs upc_regs_monitor u_upc_regs_monitor (.*);
`default_nettype wire

// ===== dv/upc_host.sv
// Serial host model: mode 0 frames, command byte then data byte
`timescale 1ns/1ps
`default_nettype none
module upc_host (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Six cycles per phase leaves margin over the two-stage synchroniser
    task automatic frame(input logic [7:0] cmd, input logic [7:0] data, output logic [7:0] rd);
        logic [15:0] word;
        word = {cmd, data};
        @(negedge i_clk) o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = word[i];
            repeat (6) @(negedge i_clk);
            o_sclk = 1'b1;
            if (i < 8) rd[i] = i_miso;
            repeat (6) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // Released line shows no stale bit
        repeat (12) @(negedge i_clk);
    endtask : frame
endmodule : upc_host
`default_nettype wire

// ===== dv/upc_regs_tb.sv
// Self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module upc_regs_tb;
    import upc_pkg::*;
    localparam logic [7:0] VID = 8'hC3; // Arbitrary identifier value
    logic I_CLK = 1'b0, I_RSTN = 1'b0, ov1 = 1'b0, ov2 = 1'b0;
    logic sclk, cs_n, mosi, miso, nvm, direct, unl, ext_wr;
    logic [3:0] sel;
    logic [16:0] cyc, ecyc;
    logic [6:0] ext_addr;
    logic [7:0] ext_data, rd, d;
    logic [15:0] ext_seen = 16'h0000;
    logic [3:0] codes [5] = '{4'h8, 4'hF, 4'h7, 4'h3, 4'h0};
    int fail_count = 0, checks_done = 0, cycles = 0, seed = 32'h0910;
    always #(CLK_PERIOD_NS / 2) I_CLK = ~I_CLK;
    // Remember the last write passed out of the slice
    always @(posedge I_CLK) if (ext_wr) ext_seen <= {1'b0, ext_addr, ext_data};
    upc_regs #(.VARIANT_ID(VID)) u_upc_regs (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_SPI_SCLK(sclk),
        .I_SPI_CS_N(cs_n), .I_SPI_MOSI(mosi), .O_SPI_MISO(miso), .I_AUX_REG1_OV(ov1),
        .I_AUX_REG2_OV(ov2), .O_ILLUMINATION_OFF_DELAY_SEL(sel), .O_OFF_DELAY_CYCLES(cyc),
        .O_NVM_PROGRAM(nvm), .O_DIRECT_MODE(direct), .O_UNLOCKED(unl), .O_EXT_WR(ext_wr),
        .O_EXT_ADDR(ext_addr), .O_EXT_DATA(ext_data));
    upc_host u_upc_host (.i_clk(I_CLK), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Least delay of a code in whole clock cycles, rounded up
    function automatic logic [16:0] exp_cycles(input logic [3:0] c);
        return 17'((OFF_DELAY_NS[c] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction : exp_cycles
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        u_upc_host.frame({1'b1, a}, v, rd);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        u_upc_host.frame({1'b0, a}, 8'h00, rd);
        check("readback", {8'h00, rd}, {8'h00, exp});
    endtask : rdchk
    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // A hung frame is cut short well past the expected run
    always @(posedge I_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (20) @(negedge I_CLK);
        I_RSTN = 1'b1;
        repeat (4) @(negedge I_CLK);
        rdchk(ADDR_OV_STATUS, 8'h00);
        rdchk(ADDR_OFF_DELAY, 8'h00);
        rdchk(ADDR_PASSWORD, 8'h00);
        rdchk(ADDR_PROTECT, 8'h00);
        rdchk(ADDR_VARIANT_ID, VID);
        for (int i = 0; i < 4; i++) begin
            {ov1, ov2} = 2'($random(seed));
            rdchk(ADDR_OV_STATUS, {6'h00, ov1, ov2});
        end
        wr(ADDR_VARIANT_ID, 8'h00);
        wr(ADDR_OV_STATUS, 8'hFF);
        rdchk(ADDR_VARIANT_ID, VID);
        rdchk(ADDR_OV_STATUS, {6'h00, ov1, ov2});
        codes[3] = 4'($random(seed));
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_OFF_DELAY, {4'h0, codes[i]});
            ecyc = exp_cycles(codes[i]);
            check("delay_sel", {12'h000, sel}, {12'h000, codes[i]});
            check("delay_cycles", cyc[15:0], ecyc[15:0]);
            check("delay_cycles_msb", {15'h0000, cyc[16]}, {15'h0000, ecyc[16]});
            rdchk(ADDR_OFF_DELAY, {4'h0, codes[i]});
        end
        wr(ADDR_PROTECT, 8'hFF);
        rdchk(ADDR_PROTECT, 8'h07);
        check("mode", {14'h0000, nvm, direct}, 16'h0003);
        wr(ADDR_OFF_DELAY, 8'h05);
        rdchk(ADDR_OFF_DELAY, 8'h00);
        d = 8'($random(seed));
        wr(ADDR_OPEN_HI, d);
        check("ext_write", ext_seen, {1'b0, ADDR_OPEN_HI, d});
        wr(7'h10, 8'h11);
        check("ext_write", ext_seen, {1'b0, ADDR_OPEN_HI, d});
        // Broken sequence first, then the proper pair
        wr(ADDR_PASSWORD, UNLOCK_FIRST);
        wr(ADDR_PASSWORD, 8'hBB);
        wr(ADDR_PASSWORD, UNLOCK_SECOND);
        check("unlocked", {15'h0000, unl}, 16'h0000);
        rdchk(ADDR_PASSWORD, UNLOCK_SECOND);
        wr(ADDR_PASSWORD, UNLOCK_FIRST);
        wr(ADDR_PASSWORD, UNLOCK_SECOND);
        check("unlocked", {15'h0000, unl}, 16'h0001);
        wr(ADDR_OFF_DELAY, 8'h09);
        rdchk(ADDR_OFF_DELAY, 8'h09);
        wr(ADDR_PROTECT, 8'h00);
        check("mode", {14'h0000, nvm, direct}, 16'h0000);
        wr(7'h10, d);
        check("ext_write", ext_seen, {1'b0, 7'h10, d});
        end_of_test();
    end
endmodule : upc_regs_tb
`default_nettype wire
